// file: core/pdpc_pkg.sv
// package: register map, field positions and reset values of the pad and power block
`default_nettype none
package pdpc_pkg;
   localparam int PDPC_AW = 16;
   localparam logic [15:0] PDPC_SER_DRIVE_ADDR = 16'h402e;
   localparam logic [15:0] PDPC_CTL_PULL_ADDR = 16'h402f;
   localparam logic [15:0] PDPC_CTL_DRIVE_ADDR = 16'h4030;
   localparam logic [15:0] PDPC_MCLK_PAD_ADDR = 16'h4031;
   localparam logic [15:0] PDPC_PWR0_ADDR = 16'h4080;
   localparam logic [15:0] PDPC_PWR1_ADDR = 16'h4081;
   localparam logic [15:0] PDPC_SER_PULL_ADDR = 16'h402d;
   // reset values
   localparam logic [3:0] PDPC_SER_DRIVE_RST = 4'h0;
   localparam logic [7:0] PDPC_CTL_PULL_RST = 8'hcf;
   localparam logic [7:0] PDPC_SER_PULL_RST = 8'hff;
   localparam logic [3:0] PDPC_CTL_DRIVE_RST = 4'h0;
   localparam logic [2:0] PDPC_MCLK_PAD_RST = 3'h1;
   localparam logic [7:0] PDPC_PWR0_RST = 8'h00;
   localparam logic [3:0] PDPC_PWR1_RST = 4'hc;
   // power register 0 bits
   localparam int PDPC_P0_ADC = 7;
   localparam int PDPC_P0_MEM = 6;
   localparam int PDPC_P0_XFER = 5;
   localparam int PDPC_P0_SPORT = 4;
   localparam int PDPC_P0_OUTRT = 3;
   localparam int PDPC_P0_INRT = 2;
   localparam int PDPC_P0_CLKGEN = 1;
   localparam int PDPC_P0_CORE = 0;
   // power register 1 bits
   localparam int PDPC_P1_PRECH = 3;
   localparam int PDPC_P1_ZCD = 2;
   localparam int PDPC_P1_DMIC = 1;
   localparam int PDPC_P1_DAC = 0;
   // pull selector codes
   localparam logic [1:0] PDPC_PULL_UP = 2'h0;
   localparam logic [1:0] PDPC_PULL_RSVD = 2'h1;
   localparam logic [1:0] PDPC_PULL_NONE = 2'h2;
   localparam logic [1:0] PDPC_PULL_DOWN = 2'h3;
endpackage
`default_nettype wire

// file: core/pdpc_regs.sv
// register bank for pad pulls, drive strengths and digital power enables
//
// Contract
// - serial pad drive bits 3..0: record out, playback in, frame, bit clock; reset 0
// - control pads have 2-bit pull selectors: 00 up, 01 reserved, 10 none, 11 down
// - control pulls reset to pull-down, except select pad resets to pull-up
// - control pad drive bits 3..0: data in, select, clock, data out; reset 0
// - master clock pad: bit2 drive, bit1 pull-up enable, bit0 pull-down enable reset 1
// - power0 bit7 low disables ADC engine and digital microphone
// - power0 bit6 low blocks memory, core, converters and port memory access
// - serial ports off only when power0 bits 5 and 4 are both low
// - power0 bit3 low disables record routing core to serial out
// - power0 bit2 low disables playback routing serial in to core
// - power0 bit1 low stops clock generator; software sets it before audio
// - power0 bit0 low disables core and its memory; needed for audio
// - power1 bit2 low disables beep zero-crossing detector; resets to one
// - power1 bit1 low disables digital microphone input
// - power1 bit0 low disables DAC engine
// - reserved bits carry no function
// - serial pads have 2-bit pull selectors with the same encoding
`timescale 1ns/1ps
`default_nettype none
module pdpc_regs
   import pdpc_pkg::*;
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_hit,
   output logic [7:0] ser_pull,
   output logic [3:0] ser_drive,
   output logic [7:0] ctl_pull,
   output logic [3:0] ctl_drive,
   output logic mclk_drive,
   output logic mclk_pull_up_en,
   output logic mclk_pull_down_en,
   output logic adc_engine_en,
   output logic dmic_en,
   output logic mem_access_en,
   output logic core_en,
   output logic adc_run,
   output logic dac_run,
   output logic sport_en,
   output logic rec_route_en,
   output logic play_route_en,
   output logic clkgen_en,
   output logic precharge_en,
   output logic zcd_en
);
   logic [7:0] ser_pull_r, next_ser_pull;
   logic [3:0] ser_drive_r, next_ser_drive;
   logic [7:0] ctl_pull_r, next_ctl_pull;
   logic [3:0] ctl_drive_r, next_ctl_drive;
   logic [2:0] mclk_r, next_mclk;
   logic [7:0] pwr0, next_pwr0;
   logic [3:0] pwr1, next_pwr1;
   logic [7:0] next_rdata;
   logic next_hit;

   // read mux; reserved pull code 01 is stored and passed to the pad as is
   function automatic logic [7:0] pdpc_readback(input logic [15:0] a,
      input logic [7:0] sp, input logic [3:0] sd, input logic [7:0] cp,
      input logic [3:0] cd, input logic [2:0] mk, input logic [7:0] p0,
      input logic [3:0] p1);
      unique case (a)
         PDPC_SER_PULL_ADDR: pdpc_readback = sp;
         PDPC_SER_DRIVE_ADDR: pdpc_readback = {4'h0, sd};
         PDPC_CTL_PULL_ADDR: pdpc_readback = cp;
         PDPC_CTL_DRIVE_ADDR: pdpc_readback = {4'h0, cd};
         PDPC_MCLK_PAD_ADDR: pdpc_readback = {5'h00, mk};
         PDPC_PWR0_ADDR: pdpc_readback = p0;
         PDPC_PWR1_ADDR: pdpc_readback = {4'h0, p1};
         default: pdpc_readback = 8'h00;
      endcase
   endfunction

   function automatic logic pdpc_mapped(input logic [15:0] a);
      pdpc_mapped = (a == PDPC_SER_PULL_ADDR) || (a == PDPC_SER_DRIVE_ADDR) ||
         (a == PDPC_CTL_PULL_ADDR) || (a == PDPC_CTL_DRIVE_ADDR) ||
         (a == PDPC_MCLK_PAD_ADDR) || (a == PDPC_PWR0_ADDR) ||
         (a == PDPC_PWR1_ADDR);
   endfunction

   // write decode; reserved upper bits are simply not stored
   always_comb begin
      next_ser_pull = ser_pull_r;
      next_ser_drive = ser_drive_r;
      next_ctl_pull = ctl_pull_r;
      next_ctl_drive = ctl_drive_r;
      next_mclk = mclk_r;
      next_pwr0 = pwr0;
      next_pwr1 = pwr1;
      if (reg_wr) begin
         unique case (reg_addr)
            PDPC_SER_PULL_ADDR: next_ser_pull = reg_wdata;
            PDPC_SER_DRIVE_ADDR: next_ser_drive = reg_wdata[3:0];
            PDPC_CTL_PULL_ADDR: next_ctl_pull = reg_wdata;
            PDPC_CTL_DRIVE_ADDR: next_ctl_drive = reg_wdata[3:0];
            PDPC_MCLK_PAD_ADDR: next_mclk = reg_wdata[2:0];
            PDPC_PWR0_ADDR: next_pwr0 = reg_wdata;
            PDPC_PWR1_ADDR: next_pwr1 = reg_wdata[3:0];
            default: next_pwr1 = pwr1;
         endcase
      end
      next_hit = (reg_wr || reg_rd) && pdpc_mapped(reg_addr);
      next_rdata = reg_rd ? pdpc_readback(reg_addr, ser_pull_r, ser_drive_r,
         ctl_pull_r, ctl_drive_r, mclk_r, pwr0, pwr1) : 8'h00;
   end

   // register storage; reset values are the power-on defaults of each field
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         ser_pull_r <= PDPC_SER_PULL_RST;
         ser_drive_r <= PDPC_SER_DRIVE_RST;
         ctl_pull_r <= PDPC_CTL_PULL_RST;
         ctl_drive_r <= PDPC_CTL_DRIVE_RST;
         mclk_r <= PDPC_MCLK_PAD_RST;
         pwr0 <= PDPC_PWR0_RST;
         pwr1 <= PDPC_PWR1_RST;
         reg_rdata <= 8'h00;
         reg_hit <= 1'b0;
      end else begin
         ser_pull_r <= next_ser_pull;
         ser_drive_r <= next_ser_drive;
         ctl_pull_r <= next_ctl_pull;
         ctl_drive_r <= next_ctl_drive;
         mclk_r <= next_mclk;
         pwr0 <= next_pwr0;
         pwr1 <= next_pwr1;
         reg_rdata <= next_rdata;
         reg_hit <= next_hit;
      end
   end

   // gating outputs, computed from next values so every output is a flop
   // that changes on the same edge as the stored register
   logic next_adc_engine_en;
   logic next_dmic_en;
   logic next_mem_access_en;
   logic next_core_en;
   logic next_adc_run;
   logic next_dac_run;
   logic next_sport_en;
   logic next_rec_route_en;
   logic next_play_route_en;
   logic next_clkgen_en;
   logic next_precharge_en;
   logic next_zcd_en;
   // memory disable also holds the core and both converter runs low
   always_comb begin
      next_mem_access_en = next_pwr0[PDPC_P0_MEM];
      next_core_en = next_pwr0[PDPC_P0_CORE] && next_mem_access_en;
      next_adc_engine_en = next_pwr0[PDPC_P0_ADC];
      next_dmic_en = next_adc_engine_en && next_pwr1[PDPC_P1_DMIC];
      next_adc_run = next_adc_engine_en && next_mem_access_en;
      next_dac_run = next_pwr1[PDPC_P1_DAC] && next_mem_access_en;
      next_sport_en = next_pwr0[PDPC_P0_XFER] || next_pwr0[PDPC_P0_SPORT];
      next_rec_route_en = next_pwr0[PDPC_P0_OUTRT];
      next_play_route_en = next_pwr0[PDPC_P0_INRT];
      next_clkgen_en = next_pwr0[PDPC_P0_CLKGEN];
      next_precharge_en = next_pwr1[PDPC_P1_PRECH];
      next_zcd_en = next_pwr1[PDPC_P1_ZCD];
   end

   // output flops; pads and gates see no glitch from the decode logic
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         ser_pull <= PDPC_SER_PULL_RST;
         ser_drive <= PDPC_SER_DRIVE_RST;
         ctl_pull <= PDPC_CTL_PULL_RST;
         ctl_drive <= PDPC_CTL_DRIVE_RST;
         mclk_drive <= PDPC_MCLK_PAD_RST[2];
         mclk_pull_up_en <= PDPC_MCLK_PAD_RST[1];
         mclk_pull_down_en <= PDPC_MCLK_PAD_RST[0];
         adc_engine_en <= 1'b0;
         dmic_en <= 1'b0;
         mem_access_en <= 1'b0;
         core_en <= 1'b0;
         adc_run <= 1'b0;
         dac_run <= 1'b0;
         sport_en <= 1'b0;
         rec_route_en <= 1'b0;
         play_route_en <= 1'b0;
         clkgen_en <= 1'b0;
         precharge_en <= PDPC_PWR1_RST[PDPC_P1_PRECH];
         zcd_en <= PDPC_PWR1_RST[PDPC_P1_ZCD];
      end else begin
         ser_pull <= next_ser_pull;
         ser_drive <= next_ser_drive;
         ctl_pull <= next_ctl_pull;
         ctl_drive <= next_ctl_drive;
         mclk_drive <= next_mclk[2];
         mclk_pull_up_en <= next_mclk[1];
         mclk_pull_down_en <= next_mclk[0];
         adc_engine_en <= next_adc_engine_en;
         dmic_en <= next_dmic_en;
         mem_access_en <= next_mem_access_en;
         core_en <= next_core_en;
         adc_run <= next_adc_run;
         dac_run <= next_dac_run;
         sport_en <= next_sport_en;
         rec_route_en <= next_rec_route_en;
         play_route_en <= next_play_route_en;
         clkgen_en <= next_clkgen_en;
         precharge_en <= next_precharge_en;
         zcd_en <= next_zcd_en;
      end
   end

   // checks tying outputs to their register cause
   sport_gate_a: assert property (@(posedge clock) disable iff (sys_rst)
      sport_en == (pwr0[PDPC_P0_XFER] || pwr0[PDPC_P0_SPORT]))
      else $error("serial port enable disagrees with power register");
   mem_gate_a: assert property (@(posedge clock) disable iff (sys_rst)
      !pwr0[PDPC_P0_MEM] |-> !core_en && !adc_run && !dac_run)
      else $error("engine running while memory disabled");
   adc_dmic_a: assert property (@(posedge clock) disable iff (sys_rst)
      !pwr0[PDPC_P0_ADC] |-> !adc_engine_en && !dmic_en)
      else $error("adc or microphone on while adc engine off");
   dmic_gate_a: assert property (@(posedge clock) disable iff (sys_rst)
      dmic_en == (pwr0[PDPC_P0_ADC] && pwr1[PDPC_P1_DMIC]))
      else $error("microphone enable wrong");
   core_gate_a: assert property (@(posedge clock) disable iff (sys_rst)
      core_en == (pwr0[PDPC_P0_CORE] && pwr0[PDPC_P0_MEM]))
      else $error("core enable wrong");
   route_out_a: assert property (@(posedge clock) disable iff (sys_rst)
      rec_route_en == pwr0[PDPC_P0_OUTRT] && play_route_en == pwr0[PDPC_P0_INRT])
      else $error("routing enable wrong");
   clkgen_out_a: assert property (@(posedge clock) disable iff (sys_rst)
      clkgen_en == pwr0[PDPC_P0_CLKGEN])
      else $error("clock generator enable wrong");
   dac_zcd_a: assert property (@(posedge clock) disable iff (sys_rst)
      dac_run == (pwr1[PDPC_P1_DAC] && pwr0[PDPC_P0_MEM]) && zcd_en == pwr1[PDPC_P1_ZCD])
      else $error("dac or zero-cross enable wrong");
   write_take_a: assert property (@(posedge clock) disable iff (sys_rst)
      reg_wr && reg_addr == PDPC_SER_DRIVE_ADDR |=> ser_drive == $past(reg_wdata[3:0]))
      else $error("drive write did not reach pad");
   mclk_write_a: assert property (@(posedge clock) disable iff (sys_rst)
      reg_wr && reg_addr == PDPC_MCLK_PAD_ADDR |=>
      {mclk_drive, mclk_pull_up_en, mclk_pull_down_en} == $past(reg_wdata[2:0]))
      else $error("master clock pad write lost");
   rsvd_read_a: assert property (@(posedge clock) disable iff (sys_rst)
      reg_rd && reg_addr == PDPC_PWR1_ADDR |=> reg_rdata[7:4] == 4'h0)
      else $error("reserved bits read nonzero");
   ctl_drive_a: assert property (@(posedge clock) disable iff (sys_rst)
      reg_wr && reg_addr == PDPC_CTL_DRIVE_ADDR |=> ctl_drive == $past(reg_wdata[3:0]))
      else $error("control drive write lost");

   // pull selectors reach the pads unchanged, reserved code included
   ser_pull_a: assert property (@(posedge clock) disable iff (sys_rst)
      reg_wr && reg_addr == PDPC_SER_PULL_ADDR |=> ser_pull == $past(reg_wdata))
      else $error("serial pull write lost");
   ctl_pull_a: assert property (@(posedge clock) disable iff (sys_rst)
      reg_wr && reg_addr == PDPC_CTL_PULL_ADDR |=> ctl_pull == $past(reg_wdata))
      else $error("control pull write lost");

   // enables that the first set of checks leaves out
   mem_out_a: assert property (@(posedge clock) disable iff (sys_rst)
      mem_access_en == pwr0[PDPC_P0_MEM])
      else $error("memory enable wrong");
   adc_out_a: assert property (@(posedge clock) disable iff (sys_rst)
      adc_engine_en == pwr0[PDPC_P0_ADC] &&
      adc_run == (pwr0[PDPC_P0_ADC] && pwr0[PDPC_P0_MEM]))
      else $error("adc enable wrong");
   prech_out_a: assert property (@(posedge clock) disable iff (sys_rst)
      precharge_en == pwr1[PDPC_P1_PRECH])
      else $error("precharge enable wrong");

   // pad and enable outputs are static levels: none of them moves without a write
   pad_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
      !reg_wr |=> $stable(ser_pull) && $stable(ser_drive) && $stable(ctl_pull) &&
      $stable(ctl_drive) && $stable({mclk_drive, mclk_pull_up_en, mclk_pull_down_en}))
      else $error("pad control moved without a write");
   en_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
      !reg_wr |=> $stable({adc_engine_en, dmic_en, mem_access_en, core_en, adc_run}) &&
      $stable({dac_run, sport_en, rec_route_en, play_route_en, clkgen_en}) &&
      $stable({precharge_en, zcd_en}))
      else $error("power enable moved without a write");

   // bus answers: hit only on mapped places, read data zero when idle
   hit_on_a: assert property (@(posedge clock) disable iff (sys_rst)
      (reg_wr || reg_rd) && pdpc_mapped(reg_addr) |=> reg_hit)
      else $error("mapped access not acknowledged");
   hit_off_a: assert property (@(posedge clock) disable iff (sys_rst)
      !((reg_wr || reg_rd) && pdpc_mapped(reg_addr)) |=> !reg_hit)
      else $error("hit without a mapped access");
   idle_rdata_a: assert property (@(posedge clock) disable iff (sys_rst)
      !reg_rd |=> reg_rdata == 8'h00)
      else $error("read data nonzero without a read");
   pwr0_read_a: assert property (@(posedge clock) disable iff (sys_rst)
      reg_rd && reg_addr == PDPC_PWR0_ADDR |=> reg_rdata == $past(pwr0))
      else $error("power register read wrong");
   rsvd_pad_read_a: assert property (@(posedge clock) disable iff (sys_rst)
      reg_rd && (reg_addr == PDPC_SER_DRIVE_ADDR || reg_addr == PDPC_CTL_DRIVE_ADDR)
      |=> reg_rdata[7:4] == 4'h0)
      else $error("reserved drive bits read nonzero");
   mclk_rsvd_a: assert property (@(posedge clock) disable iff (sys_rst)
      reg_rd && reg_addr == PDPC_MCLK_PAD_ADDR |=> reg_rdata[7:3] == 5'h00)
      else $error("reserved clock pad bits read nonzero");
endmodule
`default_nettype wire

// file: verif/tb.sv
// self-checking bench for the pad and power register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
   $display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb
   import pdpc_pkg::*;
;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [15:0] reg_addr = 16'h0000;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic reg_hit;
   logic [7:0] ser_pull;
   logic [3:0] ser_drive;
   logic [7:0] ctl_pull;
   logic [3:0] ctl_drive;
   logic mclk_drive, mclk_pull_up_en, mclk_pull_down_en;
   logic adc_engine_en, dmic_en, mem_access_en, core_en, adc_run, dac_run;
   logic sport_en, rec_route_en, play_route_en, clkgen_en, precharge_en, zcd_en;
   int num_errors = 0;
   int num_checks = 0;
   int cycles = 0;
   logic [7:0] p0;
   logic [11:0] en_vec;
   logic [26:0] pad_vec;
   // address, reset value and stored-bit mask of every mapped register
   localparam logic [15:0] ADDRS [7] = '{PDPC_SER_PULL_ADDR, PDPC_SER_DRIVE_ADDR,
      PDPC_CTL_PULL_ADDR, PDPC_CTL_DRIVE_ADDR, PDPC_MCLK_PAD_ADDR, PDPC_PWR0_ADDR, PDPC_PWR1_ADDR};
   localparam logic [7:0] RSTV [7] = '{8'hff, 8'h00, 8'hcf, 8'h00, 8'h01, 8'h00, 8'h0c};
   localparam logic [7:0] MASK [7] = '{8'hff, 8'h0f, 8'hff, 8'h0f, 8'h07, 8'hff, 8'h0f};

   assign en_vec = {adc_engine_en, dmic_en, mem_access_en, core_en, adc_run, dac_run,
      sport_en, rec_route_en, play_route_en, clkgen_en, precharge_en, zcd_en};
   assign pad_vec = {ser_pull, ser_drive, ctl_pull, ctl_drive, mclk_drive, mclk_pull_up_en,
      mclk_pull_down_en};

   pdpc_regs pdpc_regs_i (.clock(clock), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
      .ser_pull(ser_pull), .ser_drive(ser_drive), .ctl_pull(ctl_pull), .ctl_drive(ctl_drive),
      .mclk_drive(mclk_drive), .mclk_pull_up_en(mclk_pull_up_en),
      .mclk_pull_down_en(mclk_pull_down_en), .adc_engine_en(adc_engine_en), .dmic_en(dmic_en),
      .mem_access_en(mem_access_en), .core_en(core_en), .adc_run(adc_run), .dac_run(dac_run),
      .sport_en(sport_en), .rec_route_en(rec_route_en), .play_route_en(play_route_en),
      .clkgen_en(clkgen_en), .precharge_en(precharge_en), .zcd_en(zcd_en));

   // expected enables, worked out from the two power registers
   function automatic logic [11:0] exp_en(input logic [7:0] a, input logic [3:0] b);
      return {a[7], a[7] & b[1], a[6], a[0] & a[6], a[7] & a[6], b[0] & a[6],
         a[5] | a[4], a[3], a[2], a[1], b[3], b[2]};
   endfunction

   initial begin
      forever #4 clock = ~clock;
   end

   // hang guard: the whole sequence needs about 130 cycles
   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         stop_test();
      end
   end

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clock);
      #1 reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(posedge clock);
      #1 reg_wr = 1'b0;
   endtask

   // read strobe is taken at one edge, data stands for the following cycle
   task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic h);
      @(posedge clock);
      #1 reg_rd = 1'b1;
      reg_addr = a;
      @(posedge clock);
      #1 reg_rd = 1'b0;
      `CHK("reg_rdata", e, reg_rdata)
      `CHK("reg_hit", h, reg_hit)
   endtask

   task automatic stop_test();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   initial begin
      repeat (2) @(posedge clock);
      #1 sys_rst = 1'b0;
      // reset values at the pads and in the registers
      `CHK("pads", {8'hff, 4'h0, 8'hcf, 4'h0, 3'h1}, pad_vec)
      `CHK("enables", exp_en(8'h00, 4'hc), en_vec)
      for (int k = 0; k < 7; k++) rd(ADDRS[k], RSTV[k], 1'b1);
      // all ones: reserved bits must drop
      for (int k = 0; k < 7; k++) wr(ADDRS[k], 8'hff);
      for (int k = 0; k < 7; k++) rd(ADDRS[k], MASK[k], 1'b1);
      `CHK("pads", {8'hff, 4'hf, 8'hff, 4'hf, 3'h7}, pad_vec)
      `CHK("enables", exp_en(8'hff, 4'hf), en_vec)
      wr(PDPC_MCLK_PAD_ADDR, 8'hfa);
      `CHK("mclk", {1'b0, 1'b1, 1'b0}, {mclk_drive, mclk_pull_up_en, mclk_pull_down_en})
      `CHK("reg_hit", 1'b1, reg_hit)
      // unmapped places are refused
      wr(16'h4032, 8'hff);
      `CHK("reg_hit", 1'b0, reg_hit)
      `CHK("pads", {8'hff, 4'hf, 8'hff, 4'hf, 3'h2}, pad_vec)
      rd(16'h4032, 8'h00, 1'b0);
      rd(16'h402c, 8'h00, 1'b0);
      // every pull code, stored and passed to the pads unchanged
      for (int c = 0; c < 4; c++) begin
         wr(PDPC_CTL_PULL_ADDR, {4{c[1:0]}});
         wr(PDPC_SER_PULL_ADDR, {4{~c[1:0]}});
         `CHK("ctl_pull", {4{c[1:0]}}, ctl_pull)
         `CHK("ser_pull", {4{~c[1:0]}}, ser_pull)
         rd(PDPC_CTL_PULL_ADDR, {4{c[1:0]}}, 1'b1);
      end
      // power enables: each bit alone, all, all but memory
      for (int i = 0; i < 10; i++) begin
         p0 = (i == 8) ? 8'hff : (i == 9) ? 8'hbf : (8'h01 << i);
         wr(PDPC_PWR0_ADDR, p0);
         wr(PDPC_PWR1_ADDR, 8'(i));
         `CHK("enables", exp_en(p0, 4'(i)), en_vec)
      end
      wr(PDPC_PWR0_ADDR, 8'h30);
      `CHK("sport_en", 1'b1, sport_en)
      wr(PDPC_PWR1_ADDR, 8'h0c);
      // write and read in one cycle: old value read, new value stored
      @(posedge clock);
      #1 reg_wr = 1'b1;
      reg_rd = 1'b1;
      reg_addr = PDPC_CTL_DRIVE_ADDR;
      reg_wdata = 8'h05;
      @(posedge clock);
      #1 reg_wr = 1'b0;
      reg_rd = 1'b0;
      `CHK("reg_rdata", 8'h0f, reg_rdata)
      `CHK("ctl_drive", 4'h5, ctl_drive)
      // second reset in mid-run restores every default
      sys_rst = 1'b1;
      #2;
      `CHK("pads", {8'hff, 4'h0, 8'hcf, 4'h0, 3'h1}, pad_vec)
      `CHK("enables", exp_en(8'h00, 4'hc), en_vec)
      @(posedge clock);
      #1 sys_rst = 1'b0;
      rd(PDPC_CTL_PULL_ADDR, 8'hcf, 1'b1);
      rd(PDPC_PWR1_ADDR, 8'h0c, 1'b1);
      stop_test();
   end
endmodule
`default_nettype wire
